// file: hdl/dcps_pkg.sv
// package: states, command codes, timing counts for the cke power-state block
package dcps_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned CNT_W         = 9;
    localparam logic [CNT_W-1:0] XSRD_CYC = 9'h0c8;
    // times in ps, rounded up to whole clocks
    localparam int unsigned XSNR_PS   = 127500;
    localparam int unsigned XP_PS     = 2 * CLK_PERIOD_PS;
    localparam int unsigned XARD_PS   = 2 * CLK_PERIOD_PS;
    localparam int unsigned XARDS_PS  = 8 * CLK_PERIOD_PS;
    localparam int unsigned CKE_MIN   = 3;
    localparam int unsigned NBANK     = 4;
    localparam int unsigned MR_SLOW_EXIT_BIT = 12;

    // command code {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP     = 4'h7;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_READ    = 4'h5;

    typedef enum logic [2:0] {
        DCPS_ACTIVE,
        DCPS_PRE_PD,
        DCPS_ACT_PD,
        DCPS_SELF_REF
    } dcps_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
    } dcps_cmd_t;

    typedef struct packed {
        logic       buffers_on;
        logic       dll_frozen;
        logic       in_self_refresh;
        logic       in_power_down;
        logic       active_pd;
        logic       nonread_ok;
        logic       read_ok;
    } dcps_status_t;

    function automatic logic [CNT_W-1:0] cyc_up(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] XSNR_CYC  = cyc_up(XSNR_PS);
    localparam logic [CNT_W-1:0] XP_CYC    = cyc_up(XP_PS);
    localparam logic [CNT_W-1:0] XARD_CYC  = cyc_up(XARD_PS);
    localparam logic [CNT_W-1:0] XARDS_CYC = cyc_up(XARDS_PS);

endpackage

// file: hdl/dcps_exit_timer.sv
// down-counter that reports when an exit delay has elapsed
module dcps_exit_timer
    import dcps_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             start_i,
    input  wire logic [CNT_W-1:0] load_i,
    output logic                  done_o
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else if (start_i) begin
            cnt_r <= load_i;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // the last count is the edge on which the delay ends, so a command
    // sampled there is already legal
    assign done_o = (cnt_r[CNT_W-1:1] == '0) && !start_i;
endmodule

// file: hdl/dcps_top.sv
// cke-driven power-state tracker: self refresh and power-down
// Notes on behaviour
// - refresh with cke first sampled low after high and all banks idle enters self refresh
// - exit delays count from first edge sampling cke high
// - cke low with nop or deselect enters power-down
// - idle banks give precharge power-down, open row active power-down
// - power-down disables buffers; precharge power-down freezes dll
// - cke high with nop or deselect exits power-down
// - no refresh inside power-down
module dcps_top
    import dcps_pkg::*;
(
    input  wire logic                      mclk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      cke_i,
    input  wire dcps_pkg::dcps_cmd_t       cmd_i,
    input  wire logic [dcps_pkg::NBANK-1:0] bank_open_i,
    input  wire logic                      mr_slow_exit_i,
    input  wire logic                      odt_i,
    output dcps_pkg::dcps_status_t         status_o,
    output logic                           refresh_running_o,
    output logic                           cmd_violation_o
);
    import dcps_pkg::*;

    // ------------------------------------------------------------
    // cke synchroniser: three flops, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic cke_s1_r, cke_s2_r, cke_s3_r, cke_q_r, cke_prev_r;
    wire  cke_nxt = (cke_s2_r == cke_s3_r) ? cke_s3_r : cke_q_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cke_s1_r   <= 1'b1;
            cke_s2_r   <= 1'b1;
            cke_s3_r   <= 1'b1;
            cke_q_r    <= 1'b1;
            cke_prev_r <= 1'b1;
        end else begin
            cke_s1_r   <= cke_i;
            cke_s2_r   <= cke_s1_r;
            cke_s3_r   <= cke_s2_r;
            cke_q_r    <= cke_nxt;
            cke_prev_r <= cke_q_r;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire [3:0] cmd_code = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
    wire is_nop     = cmd_i.cs_n || (cmd_code == CMD_NOP);
    wire is_refresh = !cmd_i.cs_n && (cmd_code == CMD_REFRESH);
    wire is_read    = !cmd_i.cs_n && (cmd_code == CMD_READ);
    wire all_idle   = (bank_open_i == '0);
    wire fall       = cke_prev_r && !cke_q_r;
    wire rise       = !cke_prev_r && cke_q_r;

    // ------------------------------------------------------------
    // power-state machine
    // ------------------------------------------------------------
    dcps_state_t state_r, state_nxt;
    logic        from_sr_r, from_sr_nxt;
    logic        start_exit;

    always_comb begin
        state_nxt   = state_r;
        from_sr_nxt = from_sr_r;
        start_exit  = 1'b0;
        case (state_r)
            DCPS_ACTIVE: begin
                if (fall && is_refresh && all_idle) begin
                    state_nxt = DCPS_SELF_REF;
                end else if (fall && is_nop) begin
                    state_nxt = all_idle ? DCPS_PRE_PD
                                         : DCPS_ACT_PD;
                end
            end
            DCPS_PRE_PD, DCPS_ACT_PD: begin
                if (rise && is_nop) begin
                    state_nxt   = DCPS_ACTIVE;
                    from_sr_nxt = 1'b0;
                    start_exit  = 1'b1;
                end
            end
            DCPS_SELF_REF: begin
                // exit is asynchronous; counting starts at first high edge
                if (rise) begin
                    state_nxt   = DCPS_ACTIVE;
                    from_sr_nxt = 1'b1;
                    start_exit  = 1'b1;
                end
            end
            default: begin
                state_nxt = DCPS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_r   <= DCPS_ACTIVE;
            from_sr_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            from_sr_r <= from_sr_nxt;
        end
    end

    // ------------------------------------------------------------
    // exit delay timers (whole clocks, rounded up)
    // ------------------------------------------------------------
    wire sr_exit = (state_r == DCPS_SELF_REF);
    wire [CNT_W-1:0] nonread_load = sr_exit ? XSNR_CYC : XP_CYC;
    wire [CNT_W-1:0] read_load =
        sr_exit ? XSRD_CYC :
        (state_r == DCPS_ACT_PD) ?
            (mr_slow_exit_i ? XARDS_CYC : XARD_CYC) : XP_CYC;
    logic nonread_done, read_done;

    dcps_exit_timer u_nonread (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start_exit),
        .load_i    (nonread_load),
        .done_o    (nonread_done)
    );

    dcps_exit_timer u_read (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start_exit),
        .load_i    (read_load),
        .done_o    (read_done)
    );

    // ------------------------------------------------------------
    // status and command checking
    // ------------------------------------------------------------
    wire in_pd  = (state_r == DCPS_PRE_PD) || (state_r == DCPS_ACT_PD);
    wire in_sr  = (state_r == DCPS_SELF_REF);
    wire active = (state_r == DCPS_ACTIVE);
    // commands during pending exit: nops only; reads need read delay
    wire bad_cmd = active && cke_q_r &&
                   ((!nonread_done && !is_nop) ||
                    (is_read && !read_done) ||
                    (from_sr_r && !read_done && odt_i));
    dcps_status_t status_nxt;

    always_comb begin
        status_nxt.buffers_on      = !(in_pd || in_sr);
        status_nxt.dll_frozen      = (state_r == DCPS_PRE_PD) || in_sr;
        status_nxt.in_self_refresh = in_sr;
        status_nxt.in_power_down   = in_pd;
        status_nxt.active_pd       = (state_r == DCPS_ACT_PD);
        status_nxt.nonread_ok      = active && nonread_done;
        status_nxt.read_ok         = active && read_done;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            status_o          <= '0;
            refresh_running_o <= 1'b0;
            cmd_violation_o   <= 1'b0;
        end else begin
            status_o          <= status_nxt;
            refresh_running_o <= in_sr;
            cmd_violation_o   <= bad_cmd;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sr_entry;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (active && fall && is_refresh && all_idle) |=> in_sr;
    endproperty
    a_sr_entry: assert property (p_sr_entry)
        else $error("self refresh not entered");

    property p_pd_kind;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (active && fall && is_nop && !is_refresh) |=>
            (state_r == ($past(all_idle) ? DCPS_PRE_PD : DCPS_ACT_PD));
    endproperty
    a_pd_kind: assert property (p_pd_kind)
        else $error("wrong power-down kind");

    property p_pd_exit;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (in_pd && rise && is_nop) |=> active ##0 !nonread_done;
    endproperty
    a_pd_exit: assert property (p_pd_exit)
        else $error("power-down exit missed");

    property p_xsrd;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (in_sr && rise) |=> (!read_done && !start_exit) [*8];
    endproperty
    a_xsrd: assert property (p_xsrd)
        else $error("read delay ended early");

    property p_buffers;
        @(posedge mclk_i) disable iff (sys_rst_i)
        in_pd |=> !status_o.buffers_on;
    endproperty
    a_buffers: assert property (p_buffers)
        else $error("buffers on in power-down");

    property p_dll_freeze;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_r == DCPS_ACT_PD) |=> !status_o.dll_frozen;
    endproperty
    a_dll_freeze: assert property (p_dll_freeze)
        else $error("dll frozen in active power-down");

    property p_xp;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ((state_r == DCPS_PRE_PD) && rise && is_nop) |=>
            !nonread_done ##1 nonread_done;
    endproperty
    a_xp: assert property (p_xp)
        else $error("exit delay length wrong");

    property p_no_refresh_pd;
        @(posedge mclk_i) disable iff (sys_rst_i)
        in_pd |=> !refresh_running_o;
    endproperty
    a_no_refresh_pd: assert property (p_no_refresh_pd)
        else $error("refresh flagged in power-down");
endmodule

// file: dv/dcps_ctrl_model.sv
// controller-side model: drives cke, command and odt into the block
module dcps_ctrl_model (
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               cke_req_i,
    input  wire dcps_pkg::dcps_cmd_t cmd_req_i,
    input  wire logic               odt_req_i,
    output logic                    cke_o,
    output dcps_pkg::dcps_cmd_t     cmd_o,
    output logic                    odt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcps_pkg::*;
    logic [1:0] hold_r;
    // -----------------------------------------------
    // cke: a level stands three edges before it may change
    // -----------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cke_o  <= 1'b1;
            hold_r <= 2'h0;
        end else if (cke_req_i != cke_o && hold_r == 2'h2) begin
            cke_o  <= cke_req_i;
            hold_r <= 2'h0;
        end else if (hold_r != 2'h2) begin
            hold_r <= hold_r + 2'h1;
        end
    end
    // registered with cke so both reach the pins on the same edge
    always_ff @(posedge mclk_i) begin
        cmd_o <= sys_rst_i ? dcps_cmd_t'(CMD_NOP) : cmd_req_i;
        odt_o <= sys_rst_i ? 1'b0 : odt_req_i;
    end
endmodule

// file: dv/dcps_top_bench.sv
// self-checking bench for the cke power-state block
module dcps_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcps_pkg::*;
    localparam int CYC_MAX = 20000;
    logic         mclk_i, sys_rst_i, cke_req, odt_req, cke, odt;
    logic         mr_slow, refresh_running, cmd_violation, v;
    dcps_cmd_t    cmd_req, cmd;
    dcps_status_t status;
    logic [3:0]   bank_open, b;
    int           fails, check_count, cyc, t1, t2, seed;

    dcps_ctrl_model dcps_ctrl_model_inst (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .cke_req_i(cke_req), .cmd_req_i(cmd_req),
        .odt_req_i(odt_req), .cke_o(cke), .cmd_o(cmd), .odt_o(odt));
    dcps_top dcps_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .cke_i(cke), .cmd_i(cmd), .bank_open_i(bank_open),
        .mr_slow_exit_i(mr_slow), .odt_i(odt), .status_o(status),
        .refresh_running_o(refresh_running),
        .cmd_violation_o(cmd_violation));

    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == CYC_MAX) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    // -----------------------------------------------
    // checking helpers
    // -----------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string s);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: %s got %b", $time, s, got);
        end
    endtask
    task automatic chk_num(input int got, input int exp, input string s);
        check_count++;
        if (got != exp) begin
            fails++;
            $display("Error %0t: %s got %0d want %0d", $time, s, got, exp);
        end
    endtask
    function automatic int exp_gap(input logic slow);
        return slow ? int'(XARDS_CYC) - int'(XP_CYC)
                    : int'(XARD_CYC) - int'(XP_CYC);
    endfunction
    task automatic wait_hi(input int idx, output int t);
        int n;
        n = 0;
        while (status[idx] !== 1'b1 && n < 400) begin
            @(negedge mclk_i);
            n++;
        end
        chk_bit(n < 400, 1'b1, "ready flag never rose");
        t = cyc;
    endtask
    task automatic set_cke(input logic l, input logic [3:0] c, input int n);
        @(posedge mclk_i);
        cke_req <= l;
        cmd_req <= c;
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic pulse_watch(input logic [3:0] c, input logic o,
                               output logic seen);
        @(posedge mclk_i);
        cmd_req <= c;
        odt_req <= o;
        @(posedge mclk_i);
        cmd_req <= CMD_NOP;
        odt_req <= 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge mclk_i);
            if (cmd_violation === 1'b1) begin
                seen = 1'b1;
            end
        end
    endtask
    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        fails = 0;
        check_count = 0;
        cyc = 0;
        mclk_i = 0;
        sys_rst_i = 1;
        cke_req = 1;
        cmd_req = CMD_NOP;
        odt_req = 0;
        bank_open = '0;
        mr_slow = 0;
        seed = $urandom(81);
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(negedge mclk_i);
        chk_bit(status === 7'h00, 1'b1, "reset status");
        chk_bit(refresh_running, 1'b0, "reset refresh");
        // a read alongside the cke fall must not enter power-down
        set_cke(1'b0, CMD_READ, 12);
        chk_bit(status.in_power_down, 1'b0, "refused entry");
        set_cke(1'b1, CMD_NOP, 12);
        for (int i = 0; i < 6; i++) begin
            b = (i < 2) ? 4'h0 : (i == 2) ? 4'hf : 4'($urandom_range(1, 15));
            @(posedge mclk_i);
            bank_open <= b;
            mr_slow <= i[0];
            // only nops precede each drop: nothing in flight, dll locked
            set_cke(1'b0, CMD_NOP, 12);
            chk_bit(status.in_power_down, 1'b1, "pd entry");
            chk_bit(status.active_pd, |b, "pd kind");
            chk_bit(status.buffers_on, 1'b0, "buffers in pd");
            chk_bit(status.dll_frozen, b == 4'h0, "dll freeze");
            set_cke(1'b1, CMD_NOP, 0);
            wait_hi(1, t1);
            wait_hi(0, t2);
            chk_bit(status.in_power_down, 1'b0, "pd exit");
            chk_bit(status.buffers_on, 1'b1, "buffers after pd");
            if (|b) chk_num(t2 - t1, exp_gap(mr_slow), "read gap");
            repeat (4) @(negedge mclk_i);
        end
        @(posedge mclk_i);
        bank_open <= 4'h0;
        set_cke(1'b0, CMD_REFRESH, 12);
        chk_bit(status.in_self_refresh, 1'b1, "sr entry");
        chk_bit(refresh_running, 1'b1, "sr refresh");
        set_cke(1'b1, CMD_NOP, 0);
        wait_hi(1, t1);
        chk_bit(refresh_running, 1'b0, "sr exit");
        pulse_watch(CMD_READ, 1'b0, v);
        chk_bit(v, 1'b1, "early read");
        pulse_watch(CMD_NOP, 1'b1, v);
        chk_bit(v, 1'b1, "early odt");
        wait_hi(0, t2);
        chk_num(t2 - t1, int'(XSRD_CYC) - int'(XSNR_CYC),
                "sr gap");
        pulse_watch(CMD_READ, 1'b0, v);
        chk_bit(v, 1'b0, "late read");
        // second self refresh: a non-read inside the nonread delay
        set_cke(1'b0, CMD_REFRESH, 12);
        chk_bit(status.in_self_refresh, 1'b1, "sr re-entry");
        set_cke(1'b1, CMD_NOP, 0);
        // the raised cke needs about six edges to reach the state machine
        repeat (5) @(posedge mclk_i);
        pulse_watch(CMD_REFRESH, 1'b0, v);
        chk_bit(v, 1'b1, "early nonread");
        pulse_watch(CMD_REFRESH, 1'b0, v);
        chk_bit(v, 1'b0, "late nonread");
        report_and_stop();
    end
endmodule
